// File: hdl/tiofs_regs.svh
`ifndef TIOFS_REGS_SVH
`define TIOFS_REGS_SVH

// Register byte offsets
`define TIOFS_OFF_CH0_IOC 12'h000
`define TIOFS_OFF_CH1_IOC 12'h004
`define TIOFS_OFF_CH2_IOC 12'h008
`define TIOFS_OFF_CH0_MODE 12'h00C
`define TIOFS_OFF_CH1_CTRL 12'h010
`define TIOFS_OFF_RUN 12'h014
`define TIOFS_OFF_GREG0 12'h018
`define TIOFS_OFF_GREG1 12'h01C
`define TIOFS_OFF_GREG2 12'h020
`define TIOFS_OFF_STATUS 12'h024

// Field positions
`define TIOFS_FUNC_LSB 4
`define TIOFS_BUF_B_BIT 5
`define TIOFS_PSC_LSB 0

// Reset values
`define TIOFS_RST_BYTE 8'h00
`define TIOFS_RST_RUN 3'h0
`define TIOFS_PSC_UNDIVIDED 3'h0

`endif

// File: hdl/tiofs_pkg.sv
package tiofs_pkg;

    typedef logic [3:0] tiofs_func_t;

    typedef enum logic {
        TIOFS_ROLE_CMP = 1'b0,
        TIOFS_ROLE_CAP = 1'b1
    } tiofs_role_e;

    typedef struct packed {
        logic pin_in;
        logic run;
        logic hit;
        logic cascade_evt;
        logic cascade_ok;
        logic inhibit;
    } tiofs_chan_in_s;

    typedef struct packed {
        logic pin_out;
        logic pin_oe;
    } tiofs_pin_s;

endpackage

// File: hdl/tiofs_func_unit.sv
`timescale 1ns/1ps
`default_nettype none

module tiofs_func_unit
    import tiofs_pkg::*;
#(
    parameter bit HAS_CASCADE = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Function field and environment
    input wire tiofs_func_t func,
    input wire tiofs_chan_in_s ci,
    // Pin drive and capture event
    output tiofs_pin_s pin,
    output logic capture
);

    logic pin_q;
    logic from_cascade;
    logic rise;
    logic fall;
    logic pin_edge;
    logic out_q;
    logic oe_q;
    tiofs_role_e role;

    // One process per pin flop, packed into the carrier only here
    assign pin = '{pin_out: out_q, pin_oe: oe_q};

    assign role = tiofs_role_e'(func[3]);
    assign rise = ci.pin_in & ~pin_q;
    assign fall = ~ci.pin_in & pin_q;
    // Channel without cascade treats bit 2 as don't care
    assign from_cascade = HAS_CASCADE & func[2];

    always_comb begin
        if (func[1]) begin
            pin_edge = rise | fall;
        end else if (func[0]) begin
            pin_edge = fall;
        end else begin
            pin_edge = rise;
        end
    end

    // Same-cycle event so the counter value is latched without skew
    always_comb begin
        capture = 1'b0;
        if (role == TIOFS_ROLE_CAP && !ci.inhibit) begin
            if (from_cascade) begin
                capture = ci.cascade_evt & ci.cascade_ok;
            end else begin
                capture = pin_edge;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= ci.pin_in;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= role == TIOFS_ROLE_CMP && func[1:0] != 2'b00 && !ci.inhibit;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_q <= 1'b0;
        end else if (role == TIOFS_ROLE_CMP && !ci.inhibit) begin
            if (!ci.run) begin
                out_q <= func[2];
            end else if (ci.hit) begin
                case (func[1:0])
                    2'b01: out_q <= 1'b0;
                    2'b10: out_q <= 1'b1;
                    2'b11: out_q <= ~out_q;
                    default: out_q <= out_q;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence cmp_idle_s;
        role == TIOFS_ROLE_CMP && !ci.inhibit && !ci.run;
    endsequence

    sequence cmp_match_s(logic [1:0] act);
        role == TIOFS_ROLE_CMP && !ci.inhibit && ci.run && ci.hit && func[1:0] == act;
    endsequence

    sequence own_pin_s;
        role == TIOFS_ROLE_CAP && !ci.inhibit && !from_cascade;
    endsequence

    init_low_a: assert property (cmp_idle_s and !func[2] |=> !pin.pin_out)
        else $error("initial level not low");
    init_high_a: assert property (cmp_idle_s and func[2] |=> pin.pin_out)
        else $error("initial level not high");
    match_low_a: assert property (cmp_match_s(2'b01) |=> !pin.pin_out)
        else $error("match did not drive low");
    match_high_a: assert property (cmp_match_s(2'b10) |=> pin.pin_out)
        else $error("match did not drive high");
    match_toggle_a: assert property (cmp_match_s(2'b11) |=> pin.pin_out != $past(pin.pin_out))
        else $error("match did not toggle");
    rise_cap_a: assert property (own_pin_s and func[1:0] == 2'b00 |-> capture == rise)
        else $error("rising capture wrong");
    fall_cap_a: assert property (own_pin_s and func[1:0] == 2'b01 |-> capture == fall)
        else $error("falling capture wrong");
    both_cap_a: assert property (own_pin_s and func[1] |-> capture == (rise | fall))
        else $error("both-edge capture wrong");
    buf_inhibit_a: assert property (ci.inhibit |-> !capture ##1 !pin.pin_oe)
        else $error("buffer mode still acts");

endmodule

`default_nettype wire

// File: hdl/tiofs_top.sv
// Behaviour
// - Compare, bit2 clear: initial low; 00 disables
// - Compare, bit2 set: initial level high
// - Compare 01: drive pin low on match
// - Compare 10: drive pin high on match
// - Compare 11: toggle pin on match
// - Capture 1000: capture on own rising edge
// - Capture 01: capture on falling edge
// - Capture bit1 set: capture on both edges
// - Ch0 D 11xx: capture on ch1 count
// - Ch1 undivided clock: no cascade capture
// - Buffer flag set: ch0 D does nothing
// - Ch1 B cascade: capture on ch0 C event
// - Ch2 B: always own pin, bit2 ignored
// - Initial level applied only while stopped
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tiofs_regs.svh"

module tiofs_top
    import tiofs_pkg::*;
#(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Counter interface
    input wire logic [CW-1:0] ch0_counter,
    input wire logic [CW-1:0] ch1_counter,
    input wire logic [CW-1:0] ch2_counter,
    input wire logic ch1_count_tick,
    input wire logic ch0_c_event,
    output logic [2:0] counter_run_bit,
    // Timer pins
    input wire logic ch0_pin_d_in,
    output logic ch0_pin_d_out,
    output logic ch0_pin_d_oe,
    input wire logic ch1_pin_b_in,
    output logic ch1_pin_b_out,
    output logic ch1_pin_b_oe,
    input wire logic ch2_pin_b_in,
    output logic ch2_pin_b_out,
    output logic ch2_pin_b_oe
);

    logic [7:0] ch0_d_reg_io_control;
    logic [7:0] ch1_io_control;
    logic [7:0] ch2_io_control;
    logic [7:0] ch0_mode_reg;
    logic [7:0] ch1_control_reg;
    logic [CW-1:0] ch0_general_reg_d;
    logic [CW-1:0] ch1_general_reg_b;
    logic [CW-1:0] ch2_general_reg_b;
    logic [CW-1:0] prev0;
    logic [CW-1:0] prev1;
    logic [CW-1:0] prev2;
    logic acc;
    logic wr;
    logic buffer_mode_b_flag;
    logic [2:0] prescaler_sel;
    logic [2:0] cap;
    tiofs_chan_in_s ci0;
    tiofs_chan_in_s ci1;
    tiofs_chan_in_s ci2;
    tiofs_pin_s pin0;
    tiofs_pin_s pin1;
    tiofs_pin_s pin2;

    // Match once per counter step, not for every cycle it rests there
    function automatic logic cmp_hit(input logic [CW-1:0] cnt, input logic [CW-1:0] prev,
                                     input logic [CW-1:0] greg);
        return cnt == greg && cnt != prev;
    endfunction

    function automatic logic addr_ok(input logic [11:0] a);
        case (a)
            `TIOFS_OFF_CH0_IOC, `TIOFS_OFF_CH1_IOC, `TIOFS_OFF_CH2_IOC,
            `TIOFS_OFF_CH0_MODE, `TIOFS_OFF_CH1_CTRL, `TIOFS_OFF_RUN,
            `TIOFS_OFF_GREG0, `TIOFS_OFF_GREG1, `TIOFS_OFF_GREG2,
            `TIOFS_OFF_STATUS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] widen(input logic [CW-1:0] v);
        return 32'(v);
    endfunction

    assign acc = psel & penable & pready;
    assign wr = acc & pwrite & addr_ok(paddr);
    assign buffer_mode_b_flag = ch0_mode_reg[`TIOFS_BUF_B_BIT];
    assign prescaler_sel = ch1_control_reg[`TIOFS_PSC_LSB +: 3];

    // One wait state keeps every bus output on a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & penable & ~pready & ~addr_ok(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & penable & ~pready & ~pwrite) begin
            case (paddr)
                `TIOFS_OFF_CH0_IOC: prdata <= {24'h00_0000, ch0_d_reg_io_control};
                `TIOFS_OFF_CH1_IOC: prdata <= {24'h00_0000, ch1_io_control};
                `TIOFS_OFF_CH2_IOC: prdata <= {24'h00_0000, ch2_io_control};
                `TIOFS_OFF_CH0_MODE: prdata <= {24'h00_0000, ch0_mode_reg};
                `TIOFS_OFF_CH1_CTRL: prdata <= {24'h00_0000, ch1_control_reg};
                `TIOFS_OFF_RUN: prdata <= {29'h0000_0000, counter_run_bit};
                `TIOFS_OFF_GREG0: prdata <= widen(ch0_general_reg_d);
                `TIOFS_OFF_GREG1: prdata <= widen(ch1_general_reg_b);
                `TIOFS_OFF_GREG2: prdata <= widen(ch2_general_reg_b);
                `TIOFS_OFF_STATUS: prdata <= {26'h000_0000, pin2.pin_oe, pin2.pin_out,
                                              pin1.pin_oe, pin1.pin_out,
                                              pin0.pin_oe, pin0.pin_out};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch0_d_reg_io_control <= `TIOFS_RST_BYTE;
            ch1_io_control <= `TIOFS_RST_BYTE;
            ch2_io_control <= `TIOFS_RST_BYTE;
            ch0_mode_reg <= `TIOFS_RST_BYTE;
            ch1_control_reg <= `TIOFS_RST_BYTE;
            counter_run_bit <= `TIOFS_RST_RUN;
        end else if (wr) begin
            case (paddr)
                `TIOFS_OFF_CH0_IOC: ch0_d_reg_io_control <= pwdata[7:0];
                `TIOFS_OFF_CH1_IOC: ch1_io_control <= pwdata[7:0];
                `TIOFS_OFF_CH2_IOC: ch2_io_control <= pwdata[7:0];
                `TIOFS_OFF_CH0_MODE: ch0_mode_reg <= pwdata[7:0];
                `TIOFS_OFF_CH1_CTRL: ch1_control_reg <= pwdata[7:0];
                `TIOFS_OFF_RUN: counter_run_bit <= pwdata[2:0];
                default: ch0_mode_reg <= ch0_mode_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev0 <= '0;
            prev1 <= '0;
            prev2 <= '0;
        end else begin
            prev0 <= ch0_counter;
            prev1 <= ch1_counter;
            prev2 <= ch2_counter;
        end
    end

    // Capture beats a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch0_general_reg_d <= '0;
        end else if (cap[0]) begin
            ch0_general_reg_d <= ch0_counter;
        end else if (wr && paddr == `TIOFS_OFF_GREG0) begin
            ch0_general_reg_d <= pwdata[CW-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch1_general_reg_b <= '0;
        end else if (cap[1]) begin
            ch1_general_reg_b <= ch1_counter;
        end else if (wr && paddr == `TIOFS_OFF_GREG1) begin
            ch1_general_reg_b <= pwdata[CW-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch2_general_reg_b <= '0;
        end else if (cap[2]) begin
            ch2_general_reg_b <= ch2_counter;
        end else if (wr && paddr == `TIOFS_OFF_GREG2) begin
            ch2_general_reg_b <= pwdata[CW-1:0];
        end
    end

    always_comb begin
        ci0.pin_in = ch0_pin_d_in;
        ci0.run = counter_run_bit[0];
        ci0.hit = cmp_hit(ch0_counter, prev0, ch0_general_reg_d);
        ci0.cascade_evt = ch1_count_tick;
        ci0.cascade_ok = prescaler_sel != `TIOFS_PSC_UNDIVIDED;
        ci0.inhibit = buffer_mode_b_flag;
        ci1.pin_in = ch1_pin_b_in;
        ci1.run = counter_run_bit[1];
        ci1.hit = cmp_hit(ch1_counter, prev1, ch1_general_reg_b);
        ci1.cascade_evt = ch0_c_event;
        ci1.cascade_ok = 1'b1;
        ci1.inhibit = 1'b0;
        ci2.pin_in = ch2_pin_b_in;
        ci2.run = counter_run_bit[2];
        ci2.hit = cmp_hit(ch2_counter, prev2, ch2_general_reg_b);
        ci2.cascade_evt = 1'b0;
        ci2.cascade_ok = 1'b0;
        ci2.inhibit = 1'b0;
    end

    tiofs_func_unit #(.HAS_CASCADE(1'b1)) u_ch0_d (
        .clk(pclk),
        .rstn(presetn),
        .func(ch0_d_reg_io_control[`TIOFS_FUNC_LSB +: 4]),
        .ci(ci0),
        .pin(pin0),
        .capture(cap[0])
    );

    tiofs_func_unit #(.HAS_CASCADE(1'b1)) u_ch1_b (
        .clk(pclk),
        .rstn(presetn),
        .func(ch1_io_control[`TIOFS_FUNC_LSB +: 4]),
        .ci(ci1),
        .pin(pin1),
        .capture(cap[1])
    );

    tiofs_func_unit #(.HAS_CASCADE(1'b0)) u_ch2_b (
        .clk(pclk),
        .rstn(presetn),
        .func(ch2_io_control[`TIOFS_FUNC_LSB +: 4]),
        .ci(ci2),
        .pin(pin2),
        .capture(cap[2])
    );

    assign ch0_pin_d_out = pin0.pin_out;
    assign ch0_pin_d_oe = pin0.pin_oe;
    assign ch1_pin_b_out = pin1.pin_out;
    assign ch1_pin_b_oe = pin1.pin_oe;
    assign ch2_pin_b_out = pin2.pin_out;
    assign ch2_pin_b_oe = pin2.pin_oe;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    cascade_cap_a: assert property (ch0_d_reg_io_control[7:6] == 2'b11 && !buffer_mode_b_flag
        && prescaler_sel != 3'h0 |-> cap[0] == ch1_count_tick)
        else $error("ch0 cascade capture wrong");
    undivided_a: assert property (ch0_d_reg_io_control[7:6] == 2'b11
        && prescaler_sel == 3'h0 |-> !cap[0])
        else $error("cascade capture on undivided clock");
    ch0c_cap_a: assert property (ch1_io_control[7:6] == 2'b11 |-> cap[1] == ch0_c_event)
        else $error("ch1 cascade capture wrong");
    ch2_own_a: assert property (ch2_io_control[7:4] == 4'b1100
        && ch2_pin_b_in && !$past(ch2_pin_b_in) |-> cap[2])
        else $error("ch2 ignored own pin");
    cap_load_a: assert property (cap[1] |=> ch1_general_reg_b == $past(ch1_counter))
        else $error("capture value not loaded");
    apb_ready_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready not single pulse");

endmodule

`default_nettype wire

// File: tb/tiofs_partner.sv
`timescale 1ns/1ps
`default_nettype none

module tiofs_partner #(
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench controls
    input wire logic [3*CW-1:0] pre,
    input wire logic [2:0] ext,
    input wire logic c_req,
    // Device side
    input wire logic [2:0] run,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    output logic [CW-1:0] cnt0,
    output logic [CW-1:0] cnt1,
    output logic [CW-1:0] cnt2,
    output logic tick,
    output logic c_event,
    output logic [2:0] pin_in
);
    logic [CW-1:0] cnt [3];

    // Stopped counters sit at the bench preset so captures are predictable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '{default: '0};
            tick <= 1'b0;
        end else begin
            tick <= run[1];
            for (int n = 0; n < 3; n++) begin
                cnt[n] <= run[n] ? cnt[n] + 1'b1 : pre[n*CW +: CW];
            end
        end
    end

    assign cnt0 = cnt[0];
    assign cnt1 = cnt[1];
    assign cnt2 = cnt[2];
    assign c_event = c_req;
    // Driven pin reads back its own level, else the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

`default_nettype wire

// File: tb/tiofs_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tiofs_regs.svh"

module tiofs_top_tb_top;
    localparam int CW = 16;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [CW-1:0] pre0;
    logic [CW-1:0] pre1;
    logic [CW-1:0] pre2;
    logic [2:0] ext;
    logic c_req;
    wire logic [CW-1:0] c0;
    wire logic [CW-1:0] c1;
    wire logic [CW-1:0] c2;
    wire logic tick;
    wire logic cev;
    wire logic [2:0] run_bits;
    wire logic [2:0] p_out;
    wire logic [2:0] p_oe;
    wire logic [2:0] p_in;
    int mismatches;
    int total_checks;

    tiofs_top #(.CW(CW)) tiofs_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ch0_counter(c0), .ch1_counter(c1),
        .ch2_counter(c2), .ch1_count_tick(tick), .ch0_c_event(cev),
        .counter_run_bit(run_bits), .ch0_pin_d_in(p_in[0]), .ch0_pin_d_out(p_out[0]),
        .ch0_pin_d_oe(p_oe[0]), .ch1_pin_b_in(p_in[1]), .ch1_pin_b_out(p_out[1]),
        .ch1_pin_b_oe(p_oe[1]), .ch2_pin_b_in(p_in[2]), .ch2_pin_b_out(p_out[2]),
        .ch2_pin_b_oe(p_oe[2])
    );

    tiofs_partner #(.CW(CW)) tiofs_partner_i (
        .pclk(pclk), .presetn(presetn), .pre({pre2, pre1, pre0}), .ext(ext),
        .c_req(c_req), .run(run_bits), .pin_out(p_out), .pin_oe(p_oe),
        .cnt0(c0), .cnt1(c1), .cnt2(c2), .tick(tick), .c_event(cev), .pin_in(p_in)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic give_verdict();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is sampled high at a rising edge; answer taken there
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                give_verdict();
            end
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk({q[31:1], q[0] ^ e}, exp);
    endtask

    task automatic pin_chk(input int i, input logic eoe, input logic eout);
        @(negedge pclk);
        chk({30'h0, p_oe[i], p_out[i]}, {30'h0, eoe, eout});
    endtask

    task automatic t_reset();
        rdc(`TIOFS_OFF_CH0_IOC, 32'h0000_0000);
        rdc(`TIOFS_OFF_RUN, 32'h0000_0000);
        pin_chk(1, 1'b0, 1'b0);
        // Unmapped read answers zero with the error flag
        rdc(12'h100, 32'h0000_0001);
        wr(`TIOFS_OFF_CH1_IOC, 32'h0000_00A5);
        rdc(`TIOFS_OFF_CH1_IOC, 32'h0000_00A5);
    endtask

    task automatic t_compare();
        logic [3:0] f;
        logic hit;
        for (int b2 = 0; b2 < 2; b2++) begin
            for (int lo = 0; lo < 4; lo++) begin
                f = {1'b0, b2[0], lo[1:0]};
                hit = (lo == 1) ? 1'b0 : (lo == 2) ? 1'b1 : !b2[0];
                wr(`TIOFS_OFF_RUN, 32'h0000_0000);
                wr(`TIOFS_OFF_GREG1, 32'h0000_0005);
                wr(`TIOFS_OFF_CH1_IOC, {24'h0, f, 4'h0});
                cyc(3);
                pin_chk(1, lo != 0, b2[0]);
                wr(`TIOFS_OFF_RUN, 32'h0000_0002);
                cyc(12);
                if (lo != 0) pin_chk(1, 1'b1, hit);
                wr(`TIOFS_OFF_RUN, 32'h0000_0000);
                cyc(3);
                pin_chk(1, lo != 0, b2[0]);
            end
        end
    endtask

    task automatic t_capture();
        logic [3:0] fn [5] = '{4'h8, 4'hC, 4'h9, 4'hA, 4'hF};
        logic rs [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        logic fl [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        logic [31:0] exp;
        for (int k = 0; k < 5; k++) begin
            wr(`TIOFS_OFF_CH2_IOC, {24'h0, fn[k], 4'h0});
            wr(`TIOFS_OFF_GREG2, 32'h0000_0000);
            pin_chk(2, 1'b0, 1'b0);
            exp = 32'h0000_0000;
            pre2 <= 16'h0100 + k[15:0];
            cyc(2);
            ext[2] <= 1'b1;
            cyc(4);
            if (rs[k]) exp = 32'h0000_0100 + k;
            rdc(`TIOFS_OFF_GREG2, exp);
            pre2 <= 16'h0200 + k[15:0];
            cyc(2);
            ext[2] <= 1'b0;
            cyc(4);
            if (fl[k]) exp = 32'h0000_0200 + k;
            rdc(`TIOFS_OFF_GREG2, exp);
        end
    endtask

    task automatic tick_chk(input logic [31:0] exp);
        wr(`TIOFS_OFF_GREG0, 32'h0000_0000);
        wr(`TIOFS_OFF_RUN, 32'h0000_0002);
        cyc(4);
        @(negedge pclk);
        chk({29'h0000_0000, run_bits}, 32'h0000_0002);
        wr(`TIOFS_OFF_RUN, 32'h0000_0000);
        rdc(`TIOFS_OFF_GREG0, exp);
    endtask

    task automatic t_cascade();
        pre0 <= 16'h1234;
        wr(`TIOFS_OFF_CH1_CTRL, 32'h0000_0001);
        wr(`TIOFS_OFF_CH0_IOC, 32'h0000_00C0);
        tick_chk(32'h0000_1234);
        wr(`TIOFS_OFF_CH1_CTRL, 32'h0000_0000);
        tick_chk(32'h0000_0000);
        wr(`TIOFS_OFF_CH1_CTRL, 32'h0000_0001);
        wr(`TIOFS_OFF_CH0_MODE, 32'h0000_0020);
        tick_chk(32'h0000_0000);
        wr(`TIOFS_OFF_CH0_IOC, 32'h0000_0060);
        cyc(3);
        pin_chk(0, 1'b0, 1'b0);
        wr(`TIOFS_OFF_CH0_MODE, 32'h0000_0000);
        cyc(3);
        pin_chk(0, 1'b1, 1'b1);
        // Channel 1 B captures on the channel 0 C event
        wr(`TIOFS_OFF_CH1_IOC, 32'h0000_00C0);
        wr(`TIOFS_OFF_GREG1, 32'h0000_0000);
        pre1 <= 16'h0777;
        cyc(2);
        c_req <= 1'b1;
        @(posedge pclk);
        c_req <= 1'b0;
        cyc(3);
        rdc(`TIOFS_OFF_GREG1, 32'h0000_0777);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pre0 = 16'h0000;
        pre1 = 16'h0000;
        pre2 = 16'h0000;
        ext = 3'h0;
        c_req = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_compare();
        t_capture();
        t_cascade();
        give_verdict();
    end
endmodule

`default_nettype wire
